/* File: qoc_edge.sv */
// qoc_edge: valid-edge detector for the capture pin
// assumes: level input is already synchronised to clk
module qoc_edge
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic level,
	input wire logic [1:0] edge_sel,
	output logic hit
);
	logic prev_q;
	always_ff @(posedge clk)
	begin
		if (!resetn)
			prev_q <= 1'b1;
		else
			prev_q <= level;
	end
	always_comb
	begin
		case (qoc_pkg::qoc_edge_e'(edge_sel))
			qoc_pkg::EDGE_FALL: hit = prev_q & ~level;
			qoc_pkg::EDGE_RISE: hit = ~prev_q & level;
			qoc_pkg::EDGE_BOTH: hit = prev_q ^ level;
			default: hit = 1'b0;
		endcase
	end
endmodule : qoc_edge

/* File: qoc_pin_model.sv */
// qoc_pin_model: far-side source of the capture pin
// assumes: fire is a one-cycle request from the bench on clk
module qoc_pin_model
(
	input wire logic clk,
	input wire logic fire,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pin = 1'b1;
	// lands off the edge: the real pin is asynchronous to clk
	always @(posedge clk)
		if (fire)
			pin <= #1.3 ~pin;
endmodule : qoc_pin_model

/* File: qoc_pkg.sv */
// qoc_pkg: register indices, reset values, field positions and mode codes
// assumes: single clock domain, plain register port with one-cycle read data
package qoc_pkg;
	localparam int ADDR_W = 3;
	localparam logic [2:0] REG_VALUE = 3'h0;
	localparam logic [2:0] REG_SINGLE = 3'h1;
	localparam logic [2:0] REG_QUAD = 3'h2;
	localparam logic [2:0] REG_MODE = 3'h3;
	localparam logic [2:0] REG_EDGE = 3'h4;
	localparam logic [15:0] VALUE_RST = 16'h0000;
	localparam logic [7:0] SINGLE_RST = 8'hf8;
	localparam logic [7:0] QUAD_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'hf2;
	localparam logic [15:0] EDGE_RST = 16'h0000;
	localparam logic [7:0] SINGLE_FILL = 8'hf8;
	// bit 3 is a fixed zero: only bits 7:4 read as ones, so reset reads f2
	localparam logic [7:0] MODE_FILL = 8'hf0;
	localparam int SB_OUT = 0;
	localparam int SB_NEXT = 1;
	localparam int SB_CYCLE = 2;
	localparam int QB_NEXT = 4;
	localparam int MB_LO = 1;
	localparam int EB_LO = 14;
	typedef enum logic [1:0]
	{
		MODE_SINGLE = 2'b00,
		MODE_QUAD = 2'b01,
		MODE_CAPTURE = 2'b10,
		MODE_SPARE = 2'b11
	} qoc_mode_e;
	typedef enum logic [1:0]
	{
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BOTH = 2'b10,
		EDGE_NONE = 2'b11
	} qoc_edge_e;
endpackage : qoc_pkg

/* File: qoc_sync.sv */
// qoc_sync: three-stage pin synchroniser with agreement filter
// assumes: pin is asynchronous to clk
module qoc_sync
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic pin,
	output logic level
);
	logic [2:0] sh_q;
	always_ff @(posedge clk)
	begin
		if (!resetn)
			sh_q <= 3'h7;
		else
			sh_q <= {sh_q[1:0], pin};
	end
	// first stage only feeds the second; accept a change when 2 and 3 agree
	always_ff @(posedge clk)
	begin
		if (!resetn)
			level <= 1'b1;
		else if (sh_q[1] == sh_q[2])
			level <= sh_q[2];
	end
endmodule : qoc_sync

/* File: qoc_top.sv */
// qoc_top: 16-bit compare/capture module with single, quad and capture modes
// assumes: counters and their run flags come from the timer block on clk
module qoc_top
#(
	parameter int CNT_W = 16,
	parameter int NCNT = 4
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [qoc_pkg::ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [NCNT*CNT_W-1:0] counters,
	input wire logic [NCNT-1:0] counter_run,
	input wire logic [1:0] counter_source_select,
	input wire logic capture_pin_a,
	output logic [3:0] module_pins,
	output logic [3:0] pins_oe_n,
	output logic irq
);
	logic [15:0] value_q;
	logic [2:0] single_q;
	logic [7:0] quad_q;
	logic [2:0] mode_q;
	logic [15:0] edge_q;
	logic [CNT_W-1:0] cnt;
	logic running;
	logic [1:0] cur_mode;
	logic cap_level;
	logic cap_hit;
	logic match_q;
	logic match_now;
	logic cmp_event;
	logic cap_event;
	logic [15:0] cnt_word;
	logic in_single;
	logic in_quad;
	logic in_capture;
	logic cycle_done;
	logic wr_value;
	logic wr_single;
	logic wr_quad;
	logic wr_mode;
	logic wr_edge;

	function automatic logic [CNT_W-1:0] pick_cnt(
		input logic [NCNT*CNT_W-1:0] all,
		input logic [1:0] sel
	);
		pick_cnt = all[sel*CNT_W +: CNT_W];
	endfunction : pick_cnt

	// mode decode is shared by the event logic and the level bits
	function automatic logic mode_is(
		input logic [1:0] m,
		input qoc_pkg::qoc_mode_e want
	);
		mode_is = (m == want);
	endfunction : mode_is

	// a capture above the stored value counts as a completed cycle;
	// an equal or lower one leaves the flag clear
	function automatic logic cycle_check(
		input logic [15:0] now_val,
		input logic [15:0] last_val
	);
		cycle_check = (now_val > last_val);
	endfunction : cycle_check

	// write decode: an unmapped index raises no strobe, so the write is lost
	always_comb
	begin
		wr_value = 1'b0;
		wr_single = 1'b0;
		wr_quad = 1'b0;
		wr_mode = 1'b0;
		wr_edge = 1'b0;
		if (wr && addr == qoc_pkg::REG_VALUE)
			wr_value = 1'b1;
		else if (wr && addr == qoc_pkg::REG_SINGLE)
			wr_single = 1'b1;
		else if (wr && addr == qoc_pkg::REG_QUAD)
			wr_quad = 1'b1;
		else if (wr && addr == qoc_pkg::REG_MODE)
			wr_mode = 1'b1;
		else if (wr && addr == qoc_pkg::REG_EDGE)
			wr_edge = 1'b1;
	end

	assign cnt = pick_cnt(counters, counter_source_select);
	// the value register stays 16 bits whatever width the counters have
	assign cnt_word = 16'(cnt);
	assign running = counter_run[counter_source_select];
	assign cur_mode = mode_q[qoc_pkg::MB_LO +: 2];
	assign in_single = mode_is(cur_mode, qoc_pkg::MODE_SINGLE);
	assign in_quad = mode_is(cur_mode, qoc_pkg::MODE_QUAD);
	assign in_capture = mode_is(cur_mode, qoc_pkg::MODE_CAPTURE);
	assign cycle_done = cycle_check(cnt_word, value_q);

	// match is taken on its rising edge so a counter held on one value
	// produces a single event, not one per clock
	assign match_now = (value_q == cnt_word);
	assign cmp_event = running && match_now && !match_q
		&& (in_single || in_quad);
	assign cap_event = running && cap_hit && in_capture;

	qoc_sync u_sync
	(
		.clk(clk),
		.resetn(resetn),
		.pin(capture_pin_a),
		.level(cap_level)
	);

	qoc_edge u_edge
	(
		.clk(clk),
		.resetn(resetn),
		.level(cap_level),
		.edge_sel(edge_q[qoc_pkg::EB_LO +: 2]),
		.hit(cap_hit)
	);

	always_ff @(posedge clk)
	begin
		if (!resetn)
			match_q <= 1'b0;
		else
			match_q <= running && match_now;
	end

	// capture load wins over a software write in the same cycle
	always_ff @(posedge clk)
	begin
		if (!resetn)
			value_q <= qoc_pkg::VALUE_RST;
		else if (cap_event)
			value_q <= cnt_word;
		else if (wr_value)
			value_q <= wdata;
	end

	// hardware events update the level bits after any write in the cycle;
	// a read-modify-write that straddles a match can undo that update
	always_ff @(posedge clk)
	begin
		if (!resetn)
			single_q <= qoc_pkg::SINGLE_RST[2:0];
		else
		begin
			if (wr_single)
			begin
				single_q[qoc_pkg::SB_OUT] <= wdata[qoc_pkg::SB_OUT];
				single_q[qoc_pkg::SB_NEXT] <= wdata[qoc_pkg::SB_NEXT];
				if (!wdata[qoc_pkg::SB_CYCLE])
					single_q[qoc_pkg::SB_CYCLE] <= 1'b0;
			end
			if (cmp_event && in_single)
				single_q[qoc_pkg::SB_OUT] <= single_q[qoc_pkg::SB_NEXT];
			if (cap_event)
				single_q[qoc_pkg::SB_CYCLE] <= cycle_done;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			quad_q <= qoc_pkg::QUAD_RST;
		else if (cmp_event && in_quad)
			quad_q <= {quad_q[7:4], quad_q[7:4]};
		else if (wr_quad)
			quad_q <= wdata[7:0];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			mode_q <= qoc_pkg::MODE_RST[2:0];
		else if (wr_mode)
			mode_q <= wdata[2:0];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			edge_q <= qoc_pkg::EDGE_RST;
		else if (wr_edge)
			edge_q <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= cmp_event || cap_event;
	end

	// pin drive follows the mode; capture releases every pin
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			module_pins <= 4'h0;
			pins_oe_n <= 4'hf;
		end
		else
		begin
			case (qoc_pkg::qoc_mode_e'(cur_mode))
				qoc_pkg::MODE_SINGLE:
				begin
					module_pins <= {3'h0, single_q[qoc_pkg::SB_OUT]};
					pins_oe_n <= 4'he;
				end
				qoc_pkg::MODE_QUAD:
				begin
					module_pins <= quad_q[3:0];
					pins_oe_n <= 4'h0;
				end
				default:
				begin
					module_pins <= 4'h0;
					pins_oe_n <= 4'hf;
				end
			endcase
		end
	end

	// read data stand in the cycle after the strobe only
	always_ff @(posedge clk)
	begin
		if (!resetn)
			rdata <= 16'h0000;
		else if (!rd)
			rdata <= 16'h0000;
		else if (addr == qoc_pkg::REG_VALUE)
			rdata <= value_q;
		else if (addr == qoc_pkg::REG_SINGLE)
			rdata <= {8'h00, qoc_pkg::SINGLE_FILL | {5'h00, single_q}};
		else if (addr == qoc_pkg::REG_QUAD)
			rdata <= {8'h00, quad_q};
		else if (addr == qoc_pkg::REG_MODE)
			rdata <= {8'h00, qoc_pkg::MODE_FILL | {5'h00, mode_q}};
		else if (addr == qoc_pkg::REG_EDGE)
			rdata <= edge_q;
		else
			rdata <= 16'h0000;
	end
endmodule : qoc_top

/* File: qoc_top_props.sv */
// qoc_top_props: port checks for qoc_top
// assumes: bound to qoc_top; one clock, sync reset
module qoc_top_props
#(parameter int CNT_W = 16, parameter int NCNT = 4)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [qoc_pkg::ADDR_W-1:0] addr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic [NCNT-1:0] counter_run,
	input wire logic [1:0] counter_source_select,
	input wire logic [3:0] pins_oe_n,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_rd(logic [2:0] a);
		rd && addr == a;
	endsequence
	a_irq_pulse: assert property (irq |=> !irq)
		else $error("irq too long");
	a_irq_run: assert property (irq |->
		$past(counter_run[counter_source_select]))
		else $error("irq while stopped");
	a_oe_mode: assert property (
		pins_oe_n inside {4'he, 4'h0, 4'hf})
		else $error("bad enables");
	a_rst_out: assert property (disable iff (1'b0)
		!resetn |=> pins_oe_n == 4'hf && irq == 1'b0)
		else $error("outputs not reset");
	// enable register needs an edge or two to follow the reset mode
	a_quad_boot: assert property ($rose(resetn) |->
		##[1:2] pins_oe_n == 4'h0)
		else $error("not quad after reset");
	a_single_rd: assert property (s_rd(3'h1) |=>
		rdata[7:3] == 5'h1f)
		else $error("single top bits");
	a_mode_rd: assert property (s_rd(3'h3) |=>
		rdata[7:3] == 5'h1e)
		else $error("mode top bits");
	a_unmapped_read: assert property (rd && addr > 3'h4 |=>
		rdata == 16'h0)
		else $error("unmapped read");
endmodule : qoc_top_props

/* File: test_quad_output_compare_capture.sv */
// test_quad_output_compare_capture: self-checking bench for qoc_top
// assumes: qoc_pin_model drives the capture pin
module test_quad_output_compare_capture;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, resetn = 0, wr = 0, rd = 0, fire = 0, pin, irq, rd_q = 0;
	logic [2:0] addr = 0;
	logic [15:0] wdata = 0, rdata, cnt = 0, exp_q[$];
	logic [3:0] run = 0, pins, oe;
	logic [1:0] sel = 2'h3;
	logic [15:0] rst_tab[6] = '{16'h0, 16'h00f8, 16'h0, 16'h00f2, 16'h0, 16'h0};
	int fail_count = 0, samples_checked = 0;
	qoc_top uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .counters({cnt, {3{~cnt}}}),
		.counter_run(run), .counter_source_select(sel),
		.capture_pin_a(pin), .module_pins(pins), .pins_oe_n(oe), .irq(irq));
	qoc_pin_model far (.clk(clk), .fire(fire), .pin(pin));
	initial forever #2 clk = ~clk;
	task automatic report_and_stop();
		if (exp_q.size() != 0)
			fail_count++;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wreg(logic [2:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(logic [2:0] a, logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rreg
	task automatic fire_pin();
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask : fire_pin
	task automatic wait_irq();
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk);
			if (irq === 1'b1)
				return;
		end
		fail_count++;
		report_and_stop();
	endtask : wait_irq
	always @(posedge clk)
	begin
		if (rd_q)
			chk("rdata", exp_q.pop_front(), rdata);
		rd_q <= rd;
	end
	initial
	begin
		logic [3:0] q;
		void'($urandom(32'h8e9c5d2b));
		q = 4'($urandom());
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		for (int k = 0; k < 6; k++)
			rreg(3'(k), rst_tab[k]);
		wreg(3'h2, {8'h00, q, 4'h0});
		wreg(3'h0, 16'h0100);
		@(posedge clk);
		cnt <= 16'h0100;
		run <= 4'h8;
		wait_irq();
		@(negedge clk);
		chk("quad pins", {12'h0, q}, {12'h0, pins});
		chk("quad oe", 16'h0, {12'h0, oe});
		rreg(3'h2, {8'h00, q, q});
		cnt <= 16'h0;
		wreg(3'h3, 16'h00f0);
		rreg(3'h3, 16'h00f0);
		wreg(3'h1, 16'h0002);
		rreg(3'h1, 16'h00fa);
		cnt <= 16'h0100;
		wait_irq();
		@(negedge clk);
		chk("single pin", 16'h1, {12'h0, pins});
		chk("single oe", 16'h000e, {12'h0, oe});
		rreg(3'h1, 16'h00fb);
		cnt <= 16'h0200;
		wreg(3'h3, 16'h0004);
		fire_pin();
		wait_irq();
		chk("cap oe", 16'h000f, {12'h0, oe});
		rreg(3'h0, 16'h0200);
		rreg(3'h1, 16'h00ff);
		wreg(3'h1, 16'h0003);
		rreg(3'h1, 16'h00fb);
		cnt <= 16'hffaf;
		fire_pin();
		repeat (8) @(posedge clk);
		rreg(3'h0, 16'h0200);
		// counter 2 is stopped: its falling edge must not capture
		sel <= 2'h2;
		fire_pin();
		repeat (8) @(posedge clk);
		rreg(3'h0, 16'h0200);
		rreg(3'h1, 16'h00fb);
		fire_pin();
		repeat (4) @(posedge clk);
		run <= 4'h4;
		fire_pin();
		wait_irq();
		rreg(3'h0, 16'h0050);
		rreg(3'h1, 16'h00fb);
		repeat (2) @(posedge clk);
		report_and_stop();
	end
endmodule : test_quad_output_compare_capture
bind qoc_top qoc_top_props #(.CNT_W(CNT_W), .NCNT(NCNT)) chk (.clk(clk),
	.resetn(resetn), .addr(addr), .rd(rd), .rdata(rdata),
	.counter_run(counter_run), .counter_source_select(counter_source_select),
	.pins_oe_n(pins_oe_n), .irq(irq));
